// File: hbh_pkg.sv
// Constants shared by the host bus handshake block
package hbh_pkg;
  // ----------------------------------------------------------------
  // Register offsets (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [1:0] OFS_STATUS  = 2'h0;
  localparam logic [1:0] OFS_ENABLE  = 2'h1;
  localparam logic [1:0] OFS_INSERV  = 2'h2;
  // ----------------------------------------------------------------
  // bus_config_register fields
  // ----------------------------------------------------------------
  localparam int CFG_IRQ_OD   = 0;
  localparam int CFG_ACK_LSB  = 1;
  localparam int CFG_BREQ_OD  = 3;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Acknowledge input protocols
  localparam logic [1:0] ACK_LEVEL  = 2'h0;
  localparam logic [1:0] ACK_SINGLE = 2'h1;
  localparam logic [1:0] ACK_DOUBLE = 2'h2;
  // ----------------------------------------------------------------
  // Status register bits
  // ----------------------------------------------------------------
  localparam int ST_CFG_DONE = 0;
  localparam int ST_WAIT_STY = 1;
  localparam int ST_MASTER   = 2;
  localparam int ST_IRQ      = 3;
  localparam int ST_ACK      = 4;
  localparam int ST_REQ      = 5;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 40;
  localparam int ACK_READY_NS = 80;
  localparam int ACK_READY_CYC =
    ((ACK_READY_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((ACK_READY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  // Acknowledge cycle states
  typedef enum logic [2:0] {
    ACK_IDLE  = 3'b001,
    ACK_ARMED = 3'b010,
    ACK_BUSY  = 3'b100
  } hbh_ack_e;
endpackage : hbh_pkg

// File: hbh_prio.sv
// Priority resolver: highest enabled pending condition and blocking
`timescale 1ns/1ps
`default_nettype none
module hbh_prio #(
  parameter int N = 16
) (
  input  wire logic [N-1:0] i_pend,
  input  wire logic [N-1:0] i_inserv,
  output logic      [N-1:0] o_top,
  output logic              o_any,
  output logic              o_blocked
);
  // Bit 0 is the highest priority
  logic [N-1:0] top_mask;
  assign o_top     = i_pend & (~i_pend + {{(N-1){1'b0}}, 1'b1});
  assign o_any     = |i_pend;
  // Top bit and every bit above it in priority
  assign top_mask  = o_top | (o_top - {{(N-1){1'b0}}, 1'b1});
  assign o_blocked = o_any & |(i_inserv & top_mask);
endmodule : hbh_prio
`default_nettype wire

// File: hbh_top.sv
// Host bus handshake, interrupt chain and bus grant chain control
`timescale 1ns/1ps
`default_nettype none
module hbh_top #(
  parameter int N = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_ce,
  input  wire logic [1:0]   i_addr,
  input  wire logic [15:0]  i_wdata,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  input  wire logic         i_sel_serial,
  output logic      [15:0]  o_rdata,
  input  wire logic [N-1:0] i_cond,
  input  wire logic         i_hs_i,
  output logic              o_hs_o,
  output logic              o_hs_oe,
  output logic              o_master_hold,
  output logic              o_irq_n_o,
  output logic              o_irq_n_oe,
  input  wire logic         i_irq_ack_n,
  input  wire logic         i_addr_strobe_n,
  input  wire logic         i_data_strobe_n,
  input  wire logic         i_chain_enable_in,
  output logic              o_chain_enable_out,
  output logic              o_ack_answer,
  output logic      [N-1:0] o_ack_vector,
  input  wire logic         i_dma_req,
  input  wire logic         i_dma_cycle,
  input  wire logic         i_bus_request_n_i,
  output logic              o_bus_request_n_o,
  output logic              o_bus_request_n_oe,
  input  wire logic         i_grant_in_n,
  output logic              o_grant_out_n,
  output logic              o_bus_master,
  input  wire logic         i_abort_n,
  output logic              o_dma_abort
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1_reg;
  logic rst_b;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_b      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_b      <= rst_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [15:0]  cfg_reg;
  logic         cfg_done_reg;
  logic         wait_sty_reg;
  logic [N-1:0] enable_reg;
  logic [N-1:0] inserv_reg;
  logic [N-1:0] inserv_next;
  logic         acc_reg;
  wire          cfg_wr    = i_wr && !cfg_done_reg;
  wire          reg_wr    = i_wr && cfg_done_reg;
  wire          wr_enable = reg_wr && (i_addr == hbh_pkg::OFS_ENABLE);
  wire          wr_inserv = reg_wr && (i_addr == hbh_pkg::OFS_INSERV);
  wire          irq_od    = cfg_reg[hbh_pkg::CFG_IRQ_OD];
  wire          breq_od   = cfg_reg[hbh_pkg::CFG_BREQ_OD];
  wire [1:0]    ack_mode  = cfg_reg[hbh_pkg::CFG_ACK_LSB +: 2];

  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg      <= hbh_pkg::CFG_RESET;
      cfg_done_reg <= 1'b0;
      wait_sty_reg <= 1'b0;
      enable_reg   <= N'(hbh_pkg::ENABLE_RESET);
      acc_reg      <= 1'b0;
    end else if (i_ce) begin
      if (cfg_wr) begin
        cfg_reg      <= i_wdata;
        cfg_done_reg <= 1'b1;
        wait_sty_reg <= i_sel_serial;
      end
      if (wr_enable) begin
        enable_reg <= i_wdata[N-1:0];
      end
      acc_reg <= i_wr || i_rd;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt priority and request
  // ----------------------------------------------------------------
  logic [N-1:0] top;
  logic         any_pend;
  logic         blocked;
  hbh_prio #(.N(N)) u_prio (
    .i_pend    (i_cond & enable_reg),
    .i_inserv  (inserv_reg),
    .o_top     (top),
    .o_any     (any_pend),
    .o_blocked (blocked)
  );
  wire eligible = i_chain_enable_in && any_pend && !blocked;
  wire any_is   = |inserv_reg;

  // ----------------------------------------------------------------
  // Acknowledge cycle detection
  // ----------------------------------------------------------------
  hbh_pkg::hbh_ack_e ack_state_reg;
  hbh_pkg::hbh_ack_e ack_state_next;
  logic       ack_prev_reg;
  logic       as_prev_reg;
  logic       ds_prev_reg;
  logic       was_req_reg;
  logic [1:0] ack_cnt_reg;
  logic       answered_reg;
  wire ack_fall  = ack_prev_reg && !i_irq_ack_n;
  wire strb_fall = (as_prev_reg && !i_addr_strobe_n) || (ds_prev_reg && !i_data_strobe_n);
  wire lvl_start = strb_fall && !i_irq_ack_n;
  wire lvl_end   = i_addr_strobe_n && i_data_strobe_n;
  wire ack_busy  = (ack_state_reg == hbh_pkg::ACK_BUSY);
  wire ack_ready = ack_busy && (ack_cnt_reg == 2'(hbh_pkg::ACK_READY_CYC));
  wire ack_ans   = ack_ready && !answered_reg && (eligible || was_req_reg);

  always_comb begin
    ack_state_next = ack_state_reg;
    unique case (ack_state_reg)
      hbh_pkg::ACK_IDLE: begin
        if (ack_mode == hbh_pkg::ACK_LEVEL && lvl_start) begin
          ack_state_next = hbh_pkg::ACK_BUSY;
        end else if (ack_mode == hbh_pkg::ACK_SINGLE && ack_fall) begin
          ack_state_next = hbh_pkg::ACK_BUSY;
        end else if (ack_mode == hbh_pkg::ACK_DOUBLE && ack_fall) begin
          ack_state_next = hbh_pkg::ACK_ARMED;
        end
      end
      hbh_pkg::ACK_ARMED: begin
        if (ack_fall) begin
          ack_state_next = hbh_pkg::ACK_BUSY;
        end
      end
      hbh_pkg::ACK_BUSY: begin
        if (ack_mode == hbh_pkg::ACK_LEVEL ? lvl_end : i_irq_ack_n) begin
          ack_state_next = hbh_pkg::ACK_IDLE;
        end
      end
      default: ack_state_next = hbh_pkg::ACK_IDLE;
    endcase
  end

  // Set from the answer wins over a software clear in the same cycle
  assign inserv_next = (inserv_reg & ~(wr_inserv ? i_wdata[N-1:0] : {N{1'b0}}))
                     | (ack_ans ? top : {N{1'b0}});

  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_state_reg <= hbh_pkg::ACK_IDLE;
      ack_prev_reg  <= 1'b1;
      as_prev_reg   <= 1'b1;
      ds_prev_reg   <= 1'b1;
      was_req_reg   <= 1'b0;
      ack_cnt_reg   <= 2'h0;
      answered_reg  <= 1'b0;
      inserv_reg    <= {N{1'b0}};
    end else if (i_ce) begin
      ack_state_reg <= ack_state_next;
      ack_prev_reg  <= i_irq_ack_n;
      as_prev_reg   <= i_addr_strobe_n;
      ds_prev_reg   <= i_data_strobe_n;
      ack_cnt_reg   <= !ack_busy ? 2'h0 : (ack_ready ? ack_cnt_reg : ack_cnt_reg + 2'h1);
      answered_reg  <= ack_busy && (answered_reg || ack_ans);
      // Latch a request seen before or during the cycle
      was_req_reg   <= (ack_state_next != hbh_pkg::ACK_IDLE) && (was_req_reg || !o_irq_n_o);
      inserv_reg    <= inserv_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus request, grant chain and abort
  // ----------------------------------------------------------------
  logic seen_high_reg;
  logic grant_prev_reg;
  wire  grant_fall = grant_prev_reg && !i_grant_in_n;
  wire  want_bus   = i_dma_req && cfg_done_reg;
  // Open-drain waits for a free line before pulling it low
  wire  req_drive  = want_bus && (!breq_od || seen_high_reg || !o_bus_request_n_o);
  wire  take_bus   = grant_fall && (req_drive || !o_bus_request_n_o);
  wire  master_nx  = take_bus || (o_bus_master && i_dma_req);
  wire  abort_nx   = o_bus_master && i_dma_cycle && !i_abort_n;

  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_high_reg      <= 1'b0;
      grant_prev_reg     <= 1'b1;
      o_bus_request_n_o  <= 1'b1;
      o_bus_request_n_oe <= 1'b0;
      o_grant_out_n      <= 1'b1;
      o_bus_master       <= 1'b0;
      o_dma_abort        <= 1'b0;
    end else if (i_ce) begin
      seen_high_reg      <= want_bus && (seen_high_reg || i_bus_request_n_i);
      grant_prev_reg     <= i_grant_in_n;
      o_bus_request_n_o  <= !req_drive;
      o_bus_request_n_oe <= breq_od ? req_drive : 1'b1;
      if (i_grant_in_n) begin
        o_grant_out_n <= 1'b1;
      end else if (grant_fall) begin
        o_grant_out_n <= take_bus;
      end
      o_bus_master <= master_nx && !abort_nx;
      o_dma_abort  <= abort_nx;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers: handshake, interrupt, chain enable
  // ----------------------------------------------------------------
  wire irq_req = eligible && !ack_busy;
  // Wait style holds low until ready; ack style pulls low once ready
  wire hs_low  = wait_sty_reg ? (ack_busy && !ack_ready && !answered_reg)
                              : ((ack_ready || answered_reg) || acc_reg);
  wire hold_nx = wait_sty_reg ? !i_hs_i : i_hs_i;
  wire chain_nx = i_chain_enable_in && !any_is
               && !(ack_busy && (was_req_reg || eligible || !o_irq_n_o));

  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_hs_o             <= 1'b1;
      o_hs_oe            <= 1'b1;
      o_master_hold      <= 1'b0;
      o_irq_n_o          <= 1'b1;
      o_irq_n_oe         <= 1'b1;
      o_chain_enable_out <= 1'b0;
      o_ack_answer       <= 1'b0;
      o_ack_vector       <= {N{1'b0}};
      o_rdata            <= 16'h0000;
    end else if (i_ce) begin
      o_hs_o             <= !hs_low;
      o_hs_oe            <= !master_nx;
      o_master_hold      <= master_nx && hold_nx;
      o_irq_n_o          <= !irq_req;
      o_irq_n_oe         <= irq_od ? irq_req : 1'b1;
      o_chain_enable_out <= chain_nx;
      o_ack_answer       <= ack_ans;
      if (ack_ans) begin
        o_ack_vector <= top;
      end
      if (i_rd) begin
        unique case (i_addr)
          hbh_pkg::OFS_STATUS: o_rdata <= {10'h000, was_req_reg, ack_busy, !o_irq_n_o,
                                           o_bus_master, wait_sty_reg, cfg_done_reg};
          hbh_pkg::OFS_ENABLE: o_rdata <= 16'(enable_reg);
          hbh_pkg::OFS_INSERV: o_rdata <= 16'(inserv_reg);
          default:             o_rdata <= 16'h0000;
        endcase
      end else begin
        o_rdata <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_hs_release;
    @(posedge i_clk) disable iff (!rst_b)
      i_ce |=> (o_hs_oe == !$past(master_nx));
  endproperty
  a_hs_release: assert property (p_hs_release) else $error("handshake enable wrong");

  property p_style_fixed;
    @(posedge i_clk) disable iff (!rst_b)
      (cfg_done_reg && $past(cfg_done_reg)) |-> $stable(wait_sty_reg);
  endproperty
  a_style_fixed: assert property (p_style_fixed) else $error("style changed");

  property p_wait_no_acc;
    @(posedge i_clk) disable iff (!rst_b)
      (i_ce && wait_sty_reg && !ack_busy && !$past(ack_busy)) |=> o_hs_o;
  endproperty
  a_wait_no_acc: assert property (p_wait_no_acc) else $error("wait low outside ack");

  property p_ack_acc;
    @(posedge i_clk) disable iff (!rst_b)
      (cfg_done_reg && !wait_sty_reg && i_ce && (i_wr || i_rd)) ##1 i_ce |=> !o_hs_o;
  endproperty
  a_ack_acc: assert property (p_ack_acc) else $error("no acknowledge for access");

  property p_irq;
    @(posedge i_clk) disable iff (!rst_b)
      i_ce |=> (o_irq_n_o == !$past(eligible && !ack_busy));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_irq_od;
    @(posedge i_clk) disable iff (!rst_b)
      (irq_od && o_irq_n_o && $past(irq_od)) |-> !o_irq_n_oe;
  endproperty
  a_irq_od: assert property (p_irq_od) else $error("open-drain drives high");

  property p_chain;
    @(posedge i_clk) disable iff (!rst_b)
      (i_ce && (!i_chain_enable_in || any_is)) |=> !o_chain_enable_out;
  endproperty
  a_chain: assert property (p_chain) else $error("chain out high");

  property p_grant;
    @(posedge i_clk) disable iff (!rst_b)
      (i_ce && grant_fall && !take_bus) |=> !o_grant_out_n;
  endproperty
  a_grant: assert property (p_grant) else $error("grant not passed");

  property p_abort;
    @(posedge i_clk) disable iff (!rst_b)
      (i_ce && o_bus_master && i_dma_cycle && !i_abort_n) |=> (o_dma_abort && !o_bus_master);
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");

  property p_release;
    @(posedge i_clk) disable iff (!rst_b)
      (i_ce && i_grant_in_n) |=> o_grant_out_n;
  endproperty
  a_release: assert property (p_release) else $error("grant out stuck low");

  c_answer: cover property (@(posedge i_clk) disable iff (!rst_b) o_ack_answer);
  c_master: cover property (@(posedge i_clk) disable iff (!rst_b) $rose(o_bus_master));
  c_abort:  cover property (@(posedge i_clk) disable iff (!rst_b) o_dma_abort);
  c_pass:   cover property (@(posedge i_clk) disable iff (!rst_b) !o_grant_out_n);
endmodule : hbh_top
`default_nettype wire

// File: hbh_far_model.sv
// Far-side model: host handshake, bus arbiter and pulled-up shared pins
`timescale 1ns/1ps
`default_nettype none
module hbh_far_model (
  input  wire logic i_clk,
  input  wire logic i_hs_o,
  input  wire logic i_hs_oe,
  input  wire logic i_irq_n_o,
  input  wire logic i_irq_n_oe,
  input  wire logic i_breq_o,
  input  wire logic i_breq_oe,
  input  wire logic i_wait_sty,
  input  wire logic i_hs_hold,
  input  wire logic i_other_breq,
  input  wire logic i_grant_force,
  input  wire logic i_slow,
  output logic      o_hs_pin,
  output logic      o_irq_pin,
  output logic      o_breq_pin,
  output logic      o_grant_n
);
  logic [2:0] dly_reg = 3'h0;
  logic       own_req;

  // Host finishes the cycle unless told to hold; master hold needs that level
  assign o_hs_pin   = i_hs_oe ? i_hs_o : (i_hs_hold ? ~i_wait_sty : i_wait_sty);
  // Pull-ups on shared request lines
  assign o_irq_pin  = (i_irq_n_oe && !i_irq_n_o) ? 1'b0 : 1'b1;
  assign o_breq_pin = ((i_breq_oe && !i_breq_o) || i_other_breq) ? 1'b0 : 1'b1;
  // Own drive or i_grant_force earns a grant, so foreign holds alone never grant it
  assign own_req    = i_breq_oe && !i_breq_o;
  assign o_grant_n  = !(i_grant_force || (dly_reg >= (i_slow ? 3'h4 : 3'h1)));

  always @(posedge i_clk) begin
    if (!own_req) begin
      dly_reg <= 3'h0;
    end else if (dly_reg != 3'h7) begin
      dly_reg <= dly_reg + 3'h1;
    end
  end
endmodule : hbh_far_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the host bus handshake block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        i_clk, i_rst_b, i_ce, i_wr, i_rd, i_sel_serial, i_irq_ack_n;
  logic        i_addr_strobe_n, i_data_strobe_n, i_chain_enable_in;
  logic        i_dma_req, i_dma_cycle, i_abort_n;
  logic [1:0]  i_addr;
  logic [15:0] i_wdata, i_cond, o_rdata, o_ack_vector;
  logic        o_hs_o, o_hs_oe, o_master_hold, o_irq_n_o, o_irq_n_oe, o_chain_enable_out;
  logic        o_ack_answer, o_bus_request_n_o, o_bus_request_n_oe, o_grant_out_n;
  logic        o_bus_master, o_dma_abort;
  logic        wait_sty, hs_hold, other_breq, grant_force, slow;
  wire         hs_pin, irq_pin, breq_pin, grant_n;
  int          err_count = 0;
  int          tests_run = 0;
  int          n, cyc;

  hbh_top u_dut (.i_clk, .i_rst_b, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .i_sel_serial,
    .o_rdata, .i_cond, .i_hs_i(hs_pin), .o_hs_o, .o_hs_oe, .o_master_hold, .o_irq_n_o,
    .o_irq_n_oe, .i_irq_ack_n, .i_addr_strobe_n, .i_data_strobe_n, .i_chain_enable_in,
    .o_chain_enable_out, .o_ack_answer, .o_ack_vector, .i_dma_req, .i_dma_cycle,
    .i_bus_request_n_i(breq_pin), .o_bus_request_n_o, .o_bus_request_n_oe,
    .i_grant_in_n(grant_n), .o_grant_out_n, .o_bus_master, .i_abort_n, .o_dma_abort);

  hbh_far_model u_far (.i_clk, .i_hs_o(o_hs_o), .i_hs_oe(o_hs_oe), .i_irq_n_o(o_irq_n_o),
    .i_irq_n_oe(o_irq_n_oe), .i_breq_o(o_bus_request_n_o), .i_breq_oe(o_bus_request_n_oe),
    .i_wait_sty(wait_sty), .i_hs_hold(hs_hold), .i_other_breq(other_breq),
    .i_grant_force(grant_force), .i_slow(slow), .o_hs_pin(hs_pin), .o_irq_pin(irq_pin),
    .o_breq_pin(breq_pin), .o_grant_n(grant_n));

  // ------------------------------------------------------------------
  // Compare and timing helpers
  // ------------------------------------------------------------------
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic tick(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask : tick

  // Selector keeps one wait loop for ten single-bit outputs
  function automatic logic pick(input int s);
    case (s)
      0:       return o_irq_n_o;
      1:       return o_irq_n_oe;
      2:       return o_chain_enable_out;
      3:       return o_bus_master;
      4:       return o_hs_oe;
      5:       return o_master_hold;
      6:       return o_grant_out_n;
      7:       return o_bus_request_n_oe;
      8:       return o_dma_abort;
      default: return o_hs_o;
    endcase
  endfunction : pick

  task automatic wait_chk(input int s, input logic e);
    // Let the launching edge settle before the first look
    #1;
    for (int i = 0; i < 10 && pick(s) !== e; i++) tick(1);
    chk1(pick(s), e);
  endtask : wait_chk

  task automatic cnt(input int s, input logic e, input int c);
    n = 0;
    repeat (c) begin
      tick(1);
      if (pick(s) === e) n++;
    end
  endtask : cnt

  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    cnt(9, 1'b0, 5);
  endtask : wr_reg

  task automatic rd_chk(input logic [1:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk16(o_rdata & m, e);
  endtask : rd_chk

  task automatic reset_cfg(input logic sel, input logic [15:0] cfg);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    tick(1);
    chk1(o_hs_oe, 1'b1);
    chk1(o_hs_o, 1'b1);
    chk1(o_grant_out_n, 1'b1);
    chk1(o_bus_request_n_oe, 1'b0);
    @(posedge i_clk);
    i_rst_b      <= 1'b1;
    i_sel_serial <= sel;
    wait_sty     <= sel;
    repeat (3) @(posedge i_clk);
    wr_reg(hbh_pkg::OFS_STATUS, cfg);
    rd_chk(hbh_pkg::OFS_STATUS, 16'h0003, {14'h0000, sel, 1'b1});
  endtask : reset_cfg

  task automatic do_ack(input logic [1:0] p, input int k);
    logic [15:0] vec;
    logic        chain;
    int          ans;
    vec = 16'h0000;
    chain = 1'b1;
    ans = 0;
    n = 0;
    @(posedge i_clk);
    i_irq_ack_n <= 1'b0;
    if (p == hbh_pkg::ACK_DOUBLE) begin
      repeat (2) @(posedge i_clk);
      i_irq_ack_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_irq_ack_n <= 1'b0;
    end
    if (p == hbh_pkg::ACK_LEVEL) begin
      @(posedge i_clk);
      i_data_strobe_n <= 1'b0;
    end
    for (int i = 0; i < 12; i++) begin
      tick(1);
      if (o_hs_o === 1'b0) n++;
      if (o_ack_answer === 1'b1) begin
        ans++;
        vec = o_ack_vector;
        chain = o_chain_enable_out;
      end
    end
    @(posedge i_clk);
    i_irq_ack_n     <= 1'b1;
    i_data_strobe_n <= 1'b1;
    chk1(ans == 1, 1'b1);
    chk16(vec, 16'h0001 << k);
    chk1(chain, 1'b0);
    chk1(n > 0, 1'b1);
    tick(2);
  endtask : do_ack

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic test_ack_style;
    reset_cfg(1'b0, 16'h0002);
    wr_reg(hbh_pkg::OFS_ENABLE, 16'h0006);
    chk1(n > 0, 1'b1);
    rd_chk(hbh_pkg::OFS_ENABLE, 16'hffff, 16'h0006);
    rd_chk(2'h3, 16'hffff, 16'h0000);
    @(posedge i_clk);
    i_cond <= 16'h000c;
    wait_chk(0, 1'b0);
    // Clock enable low must freeze the request even when conditions vanish
    @(posedge i_clk);
    i_ce   <= 1'b0;
    i_cond <= 16'h0000;
    cnt(0, 1'b0, 4);
    chk1(n == 4, 1'b1);
    @(posedge i_clk);
    i_ce   <= 1'b1;
    i_cond <= 16'h000c;
    chk1(o_irq_n_oe, 1'b1);
    @(posedge i_clk);
    i_chain_enable_in <= 1'b0;
    wait_chk(0, 1'b1);
    wait_chk(2, 1'b0);
    @(posedge i_clk);
    i_chain_enable_in <= 1'b1;
    wait_chk(0, 1'b0);
    do_ack(hbh_pkg::ACK_SINGLE, 2);
    wait_chk(0, 1'b1);
    wait_chk(2, 1'b0);
    rd_chk(hbh_pkg::OFS_INSERV, 16'hffff, 16'h0004);
    wr_reg(hbh_pkg::OFS_INSERV, 16'h0004);
    wait_chk(0, 1'b0);
    wait_chk(2, 1'b1);
    @(posedge i_clk);
    grant_force <= 1'b1;
    wait_chk(6, 1'b0);
    @(posedge i_clk);
    grant_force <= 1'b0;
    wait_chk(6, 1'b1);
    $display("test ack_style done");
  endtask : test_ack_style

  task automatic test_wait_style;
    reset_cfg(1'b1, 16'h0005);
    wr_reg(hbh_pkg::OFS_ENABLE, 16'h0001);
    chk1(n == 0, 1'b1);
    wait_chk(1, 1'b0);
    @(posedge i_clk);
    i_cond <= 16'h0001;
    wait_chk(0, 1'b0);
    chk1(o_irq_n_oe, 1'b1);
    chk1(irq_pin, 1'b0);
    do_ack(hbh_pkg::ACK_DOUBLE, 0);
    $display("test wait_style done");
  endtask : test_wait_style

  task automatic test_bus;
    reset_cfg(1'b0, 16'h0008);
    wr_reg(hbh_pkg::OFS_ENABLE, 16'h0002);
    @(posedge i_clk);
    i_cond <= 16'h0002;
    wait_chk(0, 1'b0);
    do_ack(hbh_pkg::ACK_LEVEL, 1);
    @(posedge i_clk);
    other_breq <= 1'b1;
    slow       <= 1'b1;
    @(posedge i_clk);
    i_dma_req <= 1'b1;
    cnt(7, 1'b1, 4);
    chk1(n == 0, 1'b1);
    @(posedge i_clk);
    other_breq <= 1'b0;
    wait_chk(7, 1'b1);
    chk1(o_bus_request_n_o, 1'b0);
    wait_chk(3, 1'b1);
    chk1(o_hs_oe, 1'b0);
    chk1(o_grant_out_n, 1'b1);
    @(posedge i_clk);
    hs_hold <= 1'b1;
    wait_chk(5, 1'b1);
    @(posedge i_clk);
    hs_hold <= 1'b0;
    wait_chk(5, 1'b0);
    // Normal release drives the handshake again, then win the bus back
    @(posedge i_clk);
    i_dma_req <= 1'b0;
    wait_chk(4, 1'b1);
    wait_chk(3, 1'b0);
    @(posedge i_clk);
    i_dma_req <= 1'b1;
    wait_chk(3, 1'b1);
    @(posedge i_clk);
    i_abort_n <= 1'b0;
    cnt(8, 1'b1, 4);
    chk1(n == 0, 1'b1);
    chk1(o_bus_master, 1'b1);
    @(posedge i_clk);
    i_dma_cycle <= 1'b1;
    wait_chk(8, 1'b1);
    wait_chk(3, 1'b0);
    @(posedge i_clk);
    i_abort_n   <= 1'b1;
    i_dma_cycle <= 1'b0;
    i_dma_req   <= 1'b0;
    wait_chk(4, 1'b1);
    $display("test bus done");
  endtask : test_bus

  task automatic end_of_test;
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Whole run is a few hundred cycles; the ceiling only cuts a hang
  initial begin
    cyc = 0;
    forever begin
      @(posedge i_clk);
      cyc++;
      if (cyc > 3000) begin
        err_count++;
        end_of_test;
      end
    end
  end

  initial begin
    {i_rst_b, i_wr, i_rd, i_sel_serial, i_dma_req, i_dma_cycle} = 6'h00;
    {i_ce, i_irq_ack_n, i_addr_strobe_n, i_data_strobe_n, i_chain_enable_in, i_abort_n} = 6'h3f;
    {wait_sty, hs_hold, other_breq, grant_force, slow} = 5'h00;
    i_addr  = 2'h0;
    i_wdata = 16'h0000;
    i_cond  = 16'h0000;
    test_ack_style;
    test_wait_style;
    test_bus;
    end_of_test;
  end
endmodule : testbench
`default_nettype wire
